// ---- rtl/modulator_pkg.sv ----
package modulator_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int REG_W = 8;
  localparam logic [11:0] CTRL_OFS = 12'h000;
  localparam logic [11:0] SRC_OFS = 12'h004;

  // ----------------------------------------------------------------
  // modulation_control fields
  // ----------------------------------------------------------------
  localparam int CTL_EN_BIT = 7;
  localparam int CTL_OE_BIT = 6;
  localparam int CTL_SLR_BIT = 5;
  localparam int CTL_POL_BIT = 4;
  localparam int CTL_OUT_BIT = 3;
  localparam int CTL_SW_BIT = 0;
  localparam logic [7:0] CTRL_WMASK = 8'hF1;
  localparam logic [7:0] CTRL_RST = 8'h20;

  // ----------------------------------------------------------------
  // modulation_source_select fields
  // ----------------------------------------------------------------
  localparam int SRC_DIS_BIT = 7;
  localparam int SEL_W = 4;
  localparam int NUM_SRC = 16;
  localparam logic [7:0] SRC_WMASK = 8'h8F;
  localparam logic [7:0] SRC_RST = 8'h00;

  // ----------------------------------------------------------------
  // source codes; all others connect nothing
  // ----------------------------------------------------------------
  localparam logic [3:0] SEL_SWBIT = 4'h0;
  localparam logic [3:0] SEL_PIN = 4'h1;
  localparam logic [3:0] SEL_PWM = 4'h2;
  localparam logic [3:0] SEL_CMP1 = 4'h6;
  localparam logic [3:0] SEL_CMP2 = 4'h7;
  localparam logic [3:0] SEL_SDO = 4'h8;
  localparam logic [3:0] SEL_UTX = 4'hA;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int SYNC_STAGES = 2;

endpackage

// ---- rtl/pin_sync.sv ----
`timescale 1ns/10ps
module pin_sync
  import modulator_pkg::*;
#(
  parameter int STAGES = SYNC_STAGES
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic asyncIn,
  output logic syncOut
);

  logic [STAGES-1:0] chain_ff;

  if (STAGES < 2) begin : gBadStages
    $error("pin_sync needs at least two stages");
  end

  // only the last stage is read; earlier ones may be metastable
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      chain_ff <= '0;
    end else begin
      chain_ff <= {chain_ff[STAGES-2:0], asyncIn};
    end
  end

  assign syncOut = chain_ff[STAGES-1];

endmodule

// ---- rtl/source_select.sv ----
`timescale 1ns/10ps
module source_select
  import modulator_pkg::*;
#(
  parameter int SW = SEL_W,
  parameter int NS = NUM_SRC
) (
  input wire logic [SW-1:0] sel,
  input wire logic pinDisable,
  input wire logic swBit,
  input wire logic pinIn,
  input wire logic pwmOut,
  input wire logic cmp1Out,
  input wire logic cmp2Out,
  input wire logic sdoOut,
  input wire logic uartTxOut,
  output logic modSrc,
  output logic [NS-1:0] nxt_pinDis
);

  logic [NS-1:0] srcVec;

  if (NS != (1 << SW)) begin : gBadSlots
    $error("source_select needs one slot per select code");
  end

  // ----------------------------------------------------------------
  // source table
  // ----------------------------------------------------------------
  always_comb begin
    srcVec = '0;
    srcVec[SEL_SWBIT] = swBit;
    srcVec[SEL_PIN] = pinIn;
    srcVec[SEL_PWM] = pwmOut;
    srcVec[SEL_CMP1] = cmp1Out;
    srcVec[SEL_CMP2] = cmp2Out;
    srcVec[SEL_SDO] = sdoOut;
    srcVec[SEL_UTX] = uartTxOut;
  end

  // reserved slots stay zero, so those codes leave the input idle
  assign modSrc = srcVec[sel];

  // ----------------------------------------------------------------
  // per-source pin release
  // ----------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < NS; i++) begin : gDis
      assign nxt_pinDis[i] = pinDisable && (sel == SW'(i));
    end
  endgenerate

endmodule

// ---- rtl/modulator_source_and_control.sv ----
`timescale 1ns/10ps
// Summary of operation
// - output enable bit drives modulator output pin
// - control bit 3 reads live modulator output
// - software bit modulates only when selected
// - disable bit releases selected source's pin
// - unimplemented bits ignore writes, read zero
// - reserved select codes connect no source
// - enable bit mixes; cleared gives no output
// - polarity bit inverts the modulated output
// - reset disables module, registers take defaults
module modulator_source_and_control
  import modulator_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [DATA_W-1:0] pwdata,
  output logic pready,
  output logic [DATA_W-1:0] prdata,
  output logic pslverr,
  input wire logic modInPin,
  input wire logic carrierHigh,
  input wire logic carrierLow,
  input wire logic pwmOut,
  input wire logic cmp1Out,
  input wire logic cmp2Out,
  input wire logic sdoOut,
  input wire logic uartTxOut,
  output logic modPinOut,
  output logic modPinOe,
  output logic slewLimit,
  output logic [NUM_SRC-1:0] srcPinDisable
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic [REG_W-1:0] ctrl_ff;
  logic [REG_W-1:0] src_ff;
  logic [DATA_W-1:0] rdata_ff;
  logic out_ff;
  logic oe_ff;
  logic pinOut_ff;
  logic [NUM_SRC-1:0] pinDis_ff;
  logic [NUM_SRC-1:0] nxt_pinDis;
  logic [REG_W-1:0] nxt_ctrl;
  logic [REG_W-1:0] nxt_src;
  logic [REG_W-1:0] rdByte;
  logic nxt_out;
  logic pinSync;
  logic modSrc;
  logic mixed;
  logic hitCtrl;
  logic hitSrc;
  logic mapped;
  logic setup;
  logic wrAcc;
  logic [SEL_W-1:0] srcSel;
  logic selReserved;

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  // zero wait states keep software timing simple; no slow path exists
  assign pready = 1'b1;
  assign hitCtrl = (paddr == CTRL_OFS);
  assign hitSrc = (paddr == SRC_OFS);
  assign mapped = hitCtrl || hitSrc;
  assign setup = psel && !penable;
  assign wrAcc = psel && penable && pwrite && mapped;
  assign pslverr = psel && penable && !mapped;

  // ----------------------------------------------------------------
  // register writes
  // ----------------------------------------------------------------
  always_comb begin
    nxt_ctrl = ctrl_ff;
    if (wrAcc && hitCtrl) begin
      nxt_ctrl = pwdata[REG_W-1:0] & CTRL_WMASK;
    end
  end

  always_comb begin
    nxt_src = src_ff;
    if (wrAcc && hitSrc) begin
      nxt_src = pwdata[REG_W-1:0] & SRC_WMASK;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_ff <= CTRL_RST;
    end else begin
      ctrl_ff <= nxt_ctrl;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      src_ff <= SRC_RST;
    end else begin
      src_ff <= nxt_src;
    end
  end

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------
  // data is taken in the setup cycle so it is a flop at the access
  always_comb begin
    rdByte = '0;
    if (hitCtrl) begin
      rdByte = ctrl_ff;
      rdByte[CTL_OUT_BIT] = out_ff;
    end else if (hitSrc) begin
      rdByte = src_ff;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      rdata_ff <= '0;
    end else if (setup && !pwrite) begin
      rdata_ff <= {{(DATA_W-REG_W){1'b0}}, rdByte};
    end
  end

  assign prdata = rdata_ff;

  // ----------------------------------------------------------------
  // source selection
  // ----------------------------------------------------------------
  assign srcSel = src_ff[SEL_W-1:0];

  pin_sync #(
    .STAGES(SYNC_STAGES)
  ) uSync (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .asyncIn(modInPin),
    .syncOut(pinSync)
  );

  source_select #(
    .SW(SEL_W),
    .NS(NUM_SRC)
  ) uSel (
    .sel(srcSel),
    .pinDisable(src_ff[SRC_DIS_BIT]),
    .swBit(ctrl_ff[CTL_SW_BIT]),
    .pinIn(pinSync),
    .pwmOut(pwmOut),
    .cmp1Out(cmp1Out),
    .cmp2Out(cmp2Out),
    .sdoOut(sdoOut),
    .uartTxOut(uartTxOut),
    .modSrc(modSrc),
    .nxt_pinDis(nxt_pinDis)
  );

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      pinDis_ff <= '0;
    end else begin
      pinDis_ff <= nxt_pinDis;
    end
  end

  assign srcPinDisable = pinDis_ff;

  // ----------------------------------------------------------------
  // mixing and output
  // ----------------------------------------------------------------
  // carriers arrive already chosen; a source high picks carrier high
  assign mixed = modSrc ? carrierHigh : carrierLow;

  always_comb begin
    nxt_out = 1'b0;
    if (ctrl_ff[CTL_EN_BIT]) begin
      nxt_out = mixed ^ ctrl_ff[CTL_POL_BIT];
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      out_ff <= 1'b0;
    end else begin
      out_ff <= nxt_out;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      oe_ff <= 1'b0;
    end else begin
      oe_ff <= nxt_ctrl[CTL_OE_BIT];
    end
  end

  // the pin is held low as well as released, so no stale level leaks
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      pinOut_ff <= 1'b0;
    end else begin
      pinOut_ff <= nxt_out && nxt_ctrl[CTL_OE_BIT];
    end
  end

  assign modPinOe = oe_ff;
  assign modPinOut = pinOut_ff;
  assign slewLimit = ctrl_ff[CTL_SLR_BIT];

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  assign selReserved = !(srcSel inside {SEL_SWBIT, SEL_PIN, SEL_PWM,
    SEL_CMP1, SEL_CMP2, SEL_SDO, SEL_UTX});

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!reset_n);

  chk_pin_enable: assert property (
    wrAcc && hitCtrl |=>
      modPinOe == $past(pwdata[CTL_OE_BIT]) &&
      (!modPinOe || modPinOut == out_ff)
  ) else $error("pin enable does not follow written bit");

  chk_pin_quiet: assert property (
    !modPinOe |-> !modPinOut
  ) else $error("pin driven while output disabled");

  chk_live_status: assert property (
    setup && !pwrite && hitCtrl |=>
      prdata[CTL_OUT_BIT] == $past(out_ff) && prdata[DATA_W-1:REG_W] == '0
  ) else $error("status bit does not show modulator output");

  chk_soft_source: assert property (
    ctrl_ff[CTL_EN_BIT] && srcSel == SEL_SWBIT |=>
      out_ff == $past((ctrl_ff[CTL_SW_BIT] ? carrierHigh : carrierLow)
        ^ ctrl_ff[CTL_POL_BIT])
  ) else $error("software bit not used as source");

  chk_pin_release: assert property (
    src_ff[SRC_DIS_BIT] |=> srcPinDisable[$past(srcSel)] &&
      $onehot(srcPinDisable)
  ) else $error("selected source pin not released");

  chk_pin_keep: assert property (
    !src_ff[SRC_DIS_BIT] |=> srcPinDisable == '0
  ) else $error("source pin released while disable bit clear");

  chk_reserved_bits: assert property (
    wrAcc |=> ctrl_ff[2:1] == 2'h0 && src_ff[6:4] == 3'h0
  ) else $error("unimplemented bits took a write");

  chk_reserved_code: assert property (
    ctrl_ff[CTL_EN_BIT] && selReserved |=>
      out_ff == $past(carrierLow ^ ctrl_ff[CTL_POL_BIT])
  ) else $error("reserved code connected a source");

  chk_pwm_route: assert property (
    ctrl_ff[CTL_EN_BIT] && srcSel == SEL_PWM |=>
      out_ff == $past((pwmOut ? carrierHigh : carrierLow)
        ^ ctrl_ff[CTL_POL_BIT])
  ) else $error("pwm source not routed");

  chk_cmp1_route: assert property (
    ctrl_ff[CTL_EN_BIT] && srcSel == SEL_CMP1 |=>
      out_ff == $past((cmp1Out ? carrierHigh : carrierLow)
        ^ ctrl_ff[CTL_POL_BIT])
  ) else $error("first comparator source not routed");

  chk_cmp2_route: assert property (
    ctrl_ff[CTL_EN_BIT] && srcSel == SEL_CMP2 |=>
      out_ff == $past((cmp2Out ? carrierHigh : carrierLow)
        ^ ctrl_ff[CTL_POL_BIT])
  ) else $error("second comparator source not routed");

  chk_sdo_route: assert property (
    ctrl_ff[CTL_EN_BIT] && srcSel == SEL_SDO |=>
      out_ff == $past((sdoOut ? carrierHigh : carrierLow)
        ^ ctrl_ff[CTL_POL_BIT])
  ) else $error("serial data source not routed");

  chk_utx_route: assert property (
    ctrl_ff[CTL_EN_BIT] && srcSel == SEL_UTX |=>
      out_ff == $past((uartTxOut ? carrierHigh : carrierLow)
        ^ ctrl_ff[CTL_POL_BIT])
  ) else $error("uart transmit source not routed");

  chk_pin_route: assert property (
    ctrl_ff[CTL_EN_BIT] && srcSel == SEL_PIN && !ctrl_ff[CTL_POL_BIT] &&
      carrierHigh && !carrierLow && modInPin ##1
      (ctrl_ff[CTL_EN_BIT] && srcSel == SEL_PIN && !ctrl_ff[CTL_POL_BIT] &&
      carrierHigh && !carrierLow && modInPin) [*2] |=> out_ff
  ) else $error("input pin not routed after synchroniser");

  chk_disabled_idle: assert property (
    !ctrl_ff[CTL_EN_BIT] |=> !out_ff
  ) else $error("output active while module disabled");

  chk_invert: assert property (
    ctrl_ff[CTL_EN_BIT] && ctrl_ff[CTL_POL_BIT] |=> out_ff != $past(mixed)
  ) else $error("polarity bit did not invert output");

  chk_reset_state: assert property (
    $rose(reset_n) |-> ctrl_ff == CTRL_RST && src_ff == SRC_RST &&
      !out_ff && !modPinOe
  ) else $error("registers not at defaults after reset");

endmodule

// ---- verification/periph_model.sv ----
`timescale 1ns/10ps
module periph_model (
  input wire logic sys_clk,
  input wire logic [7:0] levels,
  input wire logic [15:0] srcPinDisable,
  output logic modInPin,
  output logic pwmOut,
  output logic cmp1Out,
  output logic cmp2Out,
  output logic sdoOut,
  output logic uartTxOut,
  output logic carrierHigh,
  output logic carrierLow,
  output logic [15:0] periphPinEn
);
  // ----------------------------------------------------------------
  // peripheral sources and carriers
  // ----------------------------------------------------------------
  // outputs move just after an edge, like real same-clock peripherals
  initial begin
    {carrierLow, carrierHigh, uartTxOut, sdoOut} = 4'h0;
    {cmp2Out, cmp1Out, pwmOut, modInPin} = 4'h0;
  end
  always @(posedge sys_clk) begin
    {carrierLow, carrierHigh, uartTxOut, sdoOut} <= levels[7:4];
    {cmp2Out, cmp1Out, pwmOut, modInPin} <= levels[3:0];
  end
  // ----------------------------------------------------------------
  // peripheral pins
  // ----------------------------------------------------------------
  // a peripheral keeps its own pin unless the modulator takes it away
  assign periphPinEn = ~srcPinDisable;
endmodule

// ---- verification/tb_top.sv ----
`timescale 1ns/10ps
module tb_top;
  import modulator_pkg::*;
  typedef struct {
    bit isPin;
    logic [32:0] val;
  } note_t;
  logic sys_clk = 1'b0;
  logic reset_n;
  logic [ADDR_W-1:0] paddr;
  logic psel, penable, pwrite, pready, pslverr, pinReq;
  logic [DATA_W-1:0] pwdata, prdata;
  logic modInPin, carrierHigh, carrierLow, pwmOut, cmp1Out, cmp2Out;
  logic sdoOut, uartTxOut, modPinOut, modPinOe, slewLimit;
  logic [NUM_SRC-1:0] srcPinDisable, periphPinEn;
  logic [7:0] levels;
  logic [31:0] wd;
  logic [18:0] pinSeen;
  logic en, oe, slr, pol, sw, dis;
  logic [3:0] code;
  note_t q[$];
  note_t cur;
  int nMismatch = 0;
  int checksDone = 0;

  always #5 sys_clk = ~sys_clk;

  modulator_source_and_control modulator_source_and_control_inst (
    .sys_clk(sys_clk), .reset_n(reset_n), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .modInPin(modInPin),
    .carrierHigh(carrierHigh), .carrierLow(carrierLow), .pwmOut(pwmOut),
    .cmp1Out(cmp1Out), .cmp2Out(cmp2Out), .sdoOut(sdoOut),
    .uartTxOut(uartTxOut), .modPinOut(modPinOut), .modPinOe(modPinOe),
    .slewLimit(slewLimit), .srcPinDisable(srcPinDisable));

  periph_model periph_model_inst (
    .sys_clk(sys_clk), .levels(levels), .srcPinDisable(srcPinDisable),
    .modInPin(modInPin), .pwmOut(pwmOut), .cmp1Out(cmp1Out),
    .cmp2Out(cmp2Out), .sdoOut(sdoOut), .uartTxOut(uartTxOut),
    .carrierHigh(carrierHigh), .carrierLow(carrierLow),
    .periphPinEn(periphPinEn));

  assign pinSeen = {srcPinDisable, slewLimit, modPinOe, modPinOut};

  // ----------------------------------------------------------------
  // expectations
  // ----------------------------------------------------------------
  function automatic logic expOut();
    logic s;
    case (code)
      SEL_SWBIT: s = sw;
      SEL_PIN: s = levels[0];
      SEL_PWM: s = levels[1];
      SEL_CMP1: s = levels[2];
      SEL_CMP2: s = levels[3];
      SEL_SDO: s = levels[4];
      SEL_UTX: s = levels[5];
      default: s = 1'b0;
    endcase
    return en ? ((s ? levels[6] : levels[7]) ^ pol) : 1'b0;
  endfunction

  // ----------------------------------------------------------------
  // reporting
  // ----------------------------------------------------------------
  task automatic summarize();
    if (nMismatch == 0 && checksDone > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic cmpReg(input logic [32:0] e, input logic [32:0] g);
    checksDone++;
    if (g !== e) begin
      nMismatch++;
      $display("[FAIL] apb read exp %h got %h", e, g);
    end
  endtask

  task automatic cmpPin(input logic [18:0] e, input logic [18:0] g);
    checksDone++;
    if (g !== e) begin
      nMismatch++;
      $display("[FAIL] pin outputs exp %h got %h", e, g);
    end
  endtask

  always @(posedge sys_clk) begin
    if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1
        && pwrite === 1'b0) begin
      cur = q.pop_front();
      cmpReg(cur.val, {pslverr, prdata});
    end
    if (pinReq === 1'b1) begin
      cur = q.pop_front();
      cmpPin(cur.val[18:0], pinSeen);
    end
  end

  // ----------------------------------------------------------------
  // drivers
  // ----------------------------------------------------------------
  task automatic apb(input logic [11:0] a, input logic w,
    input logic [31:0] d);
    int n;
    @(posedge sys_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) begin
      nMismatch++;
      summarize();
    end
  endtask

  task automatic rd(input logic [11:0] a, input logic [32:0] e);
    q.push_back('{1'b0, e});
    apb(a, 1'b0, 32'h00000000);
  endtask

  task automatic pinChk();
    logic [15:0] dv;
    dv = dis ? (16'h0001 << code) : 16'h0000;
    q.push_back('{1'b1, 33'({dv, slr, oe, expOut() & oe})});
    @(posedge sys_clk);
    pinReq <= 1'b1;
    @(posedge sys_clk);
    pinReq <= 1'b0;
  endtask

  task automatic regChk();
    pinChk();
    rd(CTRL_OFS, {1'b0, 24'h000000, en, oe, slr, pol, expOut(), 2'b00, sw});
    rd(SRC_OFS, {1'b0, 24'h000000, dis, 3'b000, code});
  endtask

  task automatic progRegs();
    wd = {24'($urandom()), dis, 3'b111, code};
    apb(SRC_OFS, 1'b1, wd);
    wd = {24'($urandom()), en, oe, slr, pol, 3'b111, sw};
    apb(CTRL_OFS, 1'b1, wd);
  endtask

  task automatic resetVals();
    {en, oe, slr, pol, sw, dis} = 6'h08;
    code = 4'h0;
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(79292));
    reset_n = 1'b0;
    {psel, penable, pwrite, pinReq} = 4'h0;
    paddr = 12'h000;
    pwdata = 32'h00000000;
    levels = 8'h00;
    resetVals();
    repeat (6) @(posedge sys_clk);
    reset_n <= 1'b1;
    regChk();
    for (int p = 0; p < 2; p++) begin
      for (int c = 0; c < 16; c++) begin
        levels <= 8'($urandom());
        {en, oe, slr, pol, sw, dis} = 6'($urandom());
        if (p == 0) begin
          {en, oe} = 2'b11;
        end
        code = c[3:0];
        // select the source before relying on the software bit
        progRegs();
        apb(12'h008, 1'b1, 32'hFFFFFFFF);
        repeat (5) @(posedge sys_clk);
        regChk();
      end
    end
    // carriers and pin held fixed so the synchronised route is exercised
    levels <= 8'h41;
    {en, oe, slr, pol, sw, dis} = 6'h30;
    code = SEL_PIN;
    progRegs();
    repeat (5) @(posedge sys_clk);
    regChk();
    rd(12'h008, {1'b1, 32'h00000000});
    // reset in mid-run must drop the pin at once
    @(posedge sys_clk);
    reset_n <= 1'b0;
    repeat (2) @(posedge sys_clk);
    reset_n <= 1'b1;
    resetVals();
    regChk();
    summarize();
  end
endmodule
